// >>> core/port_compare_set_clear_unit.sv
// Port compare unit with set/clear match registers and timer prescaler
// Notes on behaviour
// - Output count n enables compare outputs on port pins 0 through n.
// - Channel-4 mode: 00 off, 01 edge capture, 10 compare, 11 write capture.
// - Writing the low port enable bit also sets the channel-4 submode bit.
// - Submode bit clear gives compare mode 0, set gives compare mode 1.
// - Channel mode 10 with enables 01 gives concurrent compare on the port.
// - Enables 11 with channel mode 00 or 10 drive pins from set/clear matches.
// - Enables 10 give match flags only, no pins driven, any channel mode.
// - Enables 00 disable the port compare; channel 4 follows its mode bits.
// - Match, mask, enable registers reset to zero; timer control too.
// - Set and clear matches each have their own request output.
// - Timer match with a compare value sets its request flag when enabled.
// - While the match holds, neither acknowledge nor software clears the flag.
// - Acknowledge clears the flag once the match no longer holds.
// - Prescale bits select divide by 1, 2, 4 or 8.
// - The prescaler divides only in timer mode.
// - A set match drives high every enabled pin in the set mask.
// - A clear match drives low every enabled pin in the clear mask.
// - Simultaneous set and clear matches: set wins.
// - Both 16-bit compare values are always compared to the timer count.
`timescale 1ns/1ps
`default_nettype none

module port_compare_set_clear_unit
#(
    parameter int PORT_WIDTH = 8
)
(
    input  wire logic        CLK_IN,
    input  wire logic        SYS_RST_IN,
    input  wire logic [7:0]  REG_ADDR_IN,
    input  wire logic [7:0]  REG_WDATA_IN,
    input  wire logic        REG_WR_IN,
    input  wire logic        REG_RD_IN,
    output logic      [7:0]  REG_RDATA_OUT,
    input  wire logic [15:0] TIMER_COUNT_IN,
    input  wire logic        TIMER_CLOCK_TICK_IN,
    input  wire logic        TIMER_COUNTER_MODE_IN,
    input  wire logic        TIMER_PRESCALE_LOW_IN,
    output logic             TIMER_TICK_OUT,
    input  wire logic        CH4_COMPARE_LEVEL_IN,
    output logic      [1:0]  CH4_MODE_OUT,
    output logic             CH4_SUBMODE_OUT,
    input  wire logic        SET_ACK_IN,
    input  wire logic        CLR_ACK_IN,
    output logic             SET_REQUEST_OUT,
    output logic             CLR_REQUEST_OUT,
    output logic      [PORT_WIDTH-1:0] PORT_OUT,
    output logic      [PORT_WIDTH-1:0] PORT_OE_OUT
);

    // Pins 0 through n enabled
    function automatic logic [PORT_WIDTH-1:0] count_mask(input logic [2:0] n);
        logic [PORT_WIDTH-1:0] m;
        m = '0;
        for (int i = 0; i < PORT_WIDTH; i++)
        begin
            m[i] = (i <= int'(n));
        end
        return m;
    endfunction

    logic [7:0]  set_low_reg;
    logic [7:0]  set_high_reg;
    logic [7:0]  clr_low_reg;
    logic [7:0]  clr_high_reg;
    logic [7:0]  set_mask_reg;
    logic [7:0]  clr_mask_reg;
    logic [7:0]  ch4_enable_reg;
    logic [7:0]  ch4_enable_next;
    logic [7:0]  timer_control_reg;
    logic [7:0]  timer_control_next;
    logic [7:0]  rdata_reg;
    logic        set_match_prev_reg;
    logic        clr_match_prev_reg;
    logic [2:0]  prescale_count_reg;
    logic [2:0]  prescale_count_next;
    logic        tick_reg;
    logic [PORT_WIDTH-1:0] port_reg;
    logic [PORT_WIDTH-1:0] port_next;
    logic [PORT_WIDTH-1:0] oe_reg;
    logic [PORT_WIDTH-1:0] oe_next;

    wire        wr_set_low   = REG_WR_IN && (REG_ADDR_IN == port_compare_set_clear_pkg::SET_VALUE_LOW_ADDR);
    wire        wr_set_high  = REG_WR_IN && (REG_ADDR_IN == port_compare_set_clear_pkg::SET_VALUE_HIGH_ADDR);
    wire        wr_clr_low   = REG_WR_IN && (REG_ADDR_IN == port_compare_set_clear_pkg::CLR_VALUE_LOW_ADDR);
    wire        wr_clr_high  = REG_WR_IN && (REG_ADDR_IN == port_compare_set_clear_pkg::CLR_VALUE_HIGH_ADDR);
    wire        wr_set_mask  = REG_WR_IN && (REG_ADDR_IN == port_compare_set_clear_pkg::SET_PIN_MASK_ADDR);
    wire        wr_clr_mask  = REG_WR_IN && (REG_ADDR_IN == port_compare_set_clear_pkg::CLR_PIN_MASK_ADDR);
    wire        wr_ch4       = REG_WR_IN && (REG_ADDR_IN == port_compare_set_clear_pkg::CH4_ENABLE_ADDR);
    wire        wr_control   = REG_WR_IN && (REG_ADDR_IN == port_compare_set_clear_pkg::TIMER_CONTROL_ADDR);

    // Mode decoding
    wire [1:0]  ch4_mode     = {ch4_enable_reg[port_compare_set_clear_pkg::MODE_HIGH_BIT],
                                ch4_enable_reg[port_compare_set_clear_pkg::MODE_LOW_BIT]};
    wire [1:0]  port_enables = {ch4_enable_reg[port_compare_set_clear_pkg::EN_HIGH_BIT],
                                ch4_enable_reg[port_compare_set_clear_pkg::EN_LOW_BIT]};
    wire [2:0]  out_count    = ch4_enable_reg[port_compare_set_clear_pkg::COUNT_MSB:port_compare_set_clear_pkg::COUNT_LSB];
    wire [PORT_WIDTH-1:0] pin_enable = count_mask(out_count);
    // Concurrent compare needs compare mode at channel 4
    wire        concurrent   = (port_enables == port_compare_set_clear_pkg::PORT_CONCURRENT)
                            && (ch4_mode == port_compare_set_clear_pkg::CH4_COMPARE);
    // Reserved combinations fall through to disabled pins
    wire        mode_two_pins = (port_enables == port_compare_set_clear_pkg::PORT_MODE_TWO)
                            && ((ch4_mode == port_compare_set_clear_pkg::CH4_DISABLED)
                            || (ch4_mode == port_compare_set_clear_pkg::CH4_COMPARE));
    // Flags run whenever the high enable is set
    wire        flags_enabled = port_enables[1];

    // Match detection against timer count
    wire [15:0] set_value    = {set_high_reg, set_low_reg};
    wire [15:0] clr_value    = {clr_high_reg, clr_low_reg};
    wire        set_match    = (TIMER_COUNT_IN == set_value);
    wire        clr_match    = (TIMER_COUNT_IN == clr_value);
    wire        set_hit      = set_match && !set_match_prev_reg;
    wire        clr_hit      = clr_match && !clr_match_prev_reg;

    // Request flag clear requests
    wire        set_flag_clr = SET_ACK_IN
                            || (wr_control && !REG_WDATA_IN[port_compare_set_clear_pkg::SET_FLAG_BIT]);
    wire        clr_flag_clr = CLR_ACK_IN
                            || (wr_control && !REG_WDATA_IN[port_compare_set_clear_pkg::CLR_FLAG_BIT]);
    wire        set_flag_cur = timer_control_reg[port_compare_set_clear_pkg::SET_FLAG_BIT];
    wire        clr_flag_cur = timer_control_reg[port_compare_set_clear_pkg::CLR_FLAG_BIT];
    wire        set_flag_sw  = wr_control && REG_WDATA_IN[port_compare_set_clear_pkg::SET_FLAG_BIT];
    wire        clr_flag_sw  = wr_control && REG_WDATA_IN[port_compare_set_clear_pkg::CLR_FLAG_BIT];
    // Set wins; a live match blocks any clear
    wire        set_flag_next = (set_match && flags_enabled) || set_flag_sw
                            || (set_flag_cur && (!set_flag_clr || set_match));
    wire        clr_flag_next = (clr_match && flags_enabled) || clr_flag_sw
                            || (clr_flag_cur && (!clr_flag_clr || clr_match));

    // Effective pin masks in compare mode 2
    wire [PORT_WIDTH-1:0] set_pins = (set_hit ? set_mask_reg[PORT_WIDTH-1:0] : '0) & pin_enable;
    wire [PORT_WIDTH-1:0] clr_pins = (clr_hit ? clr_mask_reg[PORT_WIDTH-1:0] : '0) & pin_enable;

    // Prescaler selection
    wire [1:0]  prescale_sel = {timer_control_reg[port_compare_set_clear_pkg::PRESCALE_HIGH_BIT],
                                TIMER_PRESCALE_LOW_IN};
    wire [2:0]  prescale_last = (prescale_sel == 2'h0) ? port_compare_set_clear_pkg::DIV_ONE_LAST
                              : (prescale_sel == 2'h1) ? port_compare_set_clear_pkg::DIV_TWO_LAST
                              : (prescale_sel == 2'h2) ? port_compare_set_clear_pkg::DIV_FOUR_LAST
                              : port_compare_set_clear_pkg::DIV_EIGHT_LAST;
    wire        prescale_wrap = (prescale_count_reg >= prescale_last);
    // Counter mode passes events straight through
    wire        tick_next    = TIMER_CLOCK_TICK_IN
                            && (TIMER_COUNTER_MODE_IN || prescale_wrap);

    wire [7:0]  read_mux =
        (REG_ADDR_IN == port_compare_set_clear_pkg::SET_VALUE_LOW_ADDR)  ? set_low_reg :
        (REG_ADDR_IN == port_compare_set_clear_pkg::SET_VALUE_HIGH_ADDR) ? set_high_reg :
        (REG_ADDR_IN == port_compare_set_clear_pkg::CLR_VALUE_LOW_ADDR)  ? clr_low_reg :
        (REG_ADDR_IN == port_compare_set_clear_pkg::CLR_VALUE_HIGH_ADDR) ? clr_high_reg :
        (REG_ADDR_IN == port_compare_set_clear_pkg::SET_PIN_MASK_ADDR)   ? set_mask_reg :
        (REG_ADDR_IN == port_compare_set_clear_pkg::CLR_PIN_MASK_ADDR)   ? clr_mask_reg :
        (REG_ADDR_IN == port_compare_set_clear_pkg::CH4_ENABLE_ADDR)     ? ch4_enable_reg :
        (REG_ADDR_IN == port_compare_set_clear_pkg::TIMER_CONTROL_ADDR)  ? timer_control_reg :
        8'h00;

    always_comb
    begin
        ch4_enable_next = ch4_enable_reg;
        if (wr_ch4)
        begin
            ch4_enable_next = REG_WDATA_IN;
            if (REG_WDATA_IN[port_compare_set_clear_pkg::EN_LOW_BIT])
            begin
                ch4_enable_next[port_compare_set_clear_pkg::SUBMODE_BIT] = 1'b1;
            end
        end
    end

    always_comb
    begin
        timer_control_next = timer_control_reg;
        if (wr_control)
        begin
            timer_control_next = REG_WDATA_IN & port_compare_set_clear_pkg::TIMER_CONTROL_MASK;
        end
        timer_control_next[port_compare_set_clear_pkg::SET_FLAG_BIT] = set_flag_next;
        timer_control_next[port_compare_set_clear_pkg::CLR_FLAG_BIT] = clr_flag_next;
    end

    always_comb
    begin
        port_next = port_reg;
        oe_next   = '0;
        if (concurrent)
        begin
            oe_next   = pin_enable;
            port_next = (port_reg & ~pin_enable)
                      | ({PORT_WIDTH{CH4_COMPARE_LEVEL_IN}} & pin_enable);
        end
        else if (mode_two_pins)
        begin
            oe_next   = pin_enable;
            port_next = (port_reg & ~clr_pins) | set_pins;
        end
    end

    always_comb
    begin
        prescale_count_next = prescale_count_reg;
        if (TIMER_COUNTER_MODE_IN)
        begin
            prescale_count_next = 3'h0;
        end
        else if (TIMER_CLOCK_TICK_IN)
        begin
            prescale_count_next = prescale_wrap ? 3'h0 : prescale_count_reg + 3'h1;
        end
    end

    always_ff @(posedge CLK_IN)
    begin
        if (SYS_RST_IN)
        begin
            set_low_reg       <= port_compare_set_clear_pkg::REG_RESET;
            set_high_reg      <= port_compare_set_clear_pkg::REG_RESET;
            clr_low_reg       <= port_compare_set_clear_pkg::REG_RESET;
            clr_high_reg      <= port_compare_set_clear_pkg::REG_RESET;
            set_mask_reg      <= port_compare_set_clear_pkg::REG_RESET;
            clr_mask_reg      <= port_compare_set_clear_pkg::REG_RESET;
            ch4_enable_reg    <= port_compare_set_clear_pkg::REG_RESET;
            timer_control_reg <= port_compare_set_clear_pkg::TIMER_CONTROL_RESET;
        end
        else
        begin
            set_low_reg       <= wr_set_low  ? REG_WDATA_IN : set_low_reg;
            set_high_reg      <= wr_set_high ? REG_WDATA_IN : set_high_reg;
            clr_low_reg       <= wr_clr_low  ? REG_WDATA_IN : clr_low_reg;
            clr_high_reg      <= wr_clr_high ? REG_WDATA_IN : clr_high_reg;
            set_mask_reg      <= wr_set_mask ? REG_WDATA_IN : set_mask_reg;
            clr_mask_reg      <= wr_clr_mask ? REG_WDATA_IN : clr_mask_reg;
            ch4_enable_reg    <= ch4_enable_next;
            timer_control_reg <= timer_control_next;
        end
    end

    always_ff @(posedge CLK_IN)
    begin
        if (SYS_RST_IN)
        begin
            rdata_reg          <= 8'h00;
            set_match_prev_reg <= 1'b0;
            clr_match_prev_reg <= 1'b0;
            prescale_count_reg <= 3'h0;
            tick_reg           <= 1'b0;
            port_reg           <= '0;
            oe_reg             <= '0;
        end
        else
        begin
            rdata_reg          <= REG_RD_IN ? read_mux : 8'h00;
            set_match_prev_reg <= set_match;
            clr_match_prev_reg <= clr_match;
            prescale_count_reg <= prescale_count_next;
            tick_reg           <= tick_next;
            port_reg           <= port_next;
            oe_reg             <= oe_next;
        end
    end

    assign REG_RDATA_OUT   = rdata_reg;
    assign TIMER_TICK_OUT  = tick_reg;
    assign CH4_MODE_OUT    = ch4_mode;
    assign CH4_SUBMODE_OUT = ch4_enable_reg[port_compare_set_clear_pkg::SUBMODE_BIT];
    assign SET_REQUEST_OUT = set_flag_cur;
    assign CLR_REQUEST_OUT = clr_flag_cur;
    assign PORT_OUT        = port_reg;
    assign PORT_OE_OUT     = oe_reg;

    // Checks
    sequence s_low_enable_write;
        wr_ch4 && REG_WDATA_IN[port_compare_set_clear_pkg::EN_LOW_BIT];
    endsequence

    sequence s_set_event;
        mode_two_pins && set_hit;
    endsequence

    property p_autoset_submode;
        @(posedge CLK_IN) disable iff (SYS_RST_IN)
        s_low_enable_write |=> CH4_SUBMODE_OUT;
    endproperty
    a_autoset_submode: assert property (p_autoset_submode) else $error("submode not set");

    property p_flag_on_match;
        @(posedge CLK_IN) disable iff (SYS_RST_IN)
        set_match && flags_enabled |=> SET_REQUEST_OUT;
    endproperty
    a_flag_on_match: assert property (p_flag_on_match) else $error("set flag missed");

    property p_flag_held;
        @(posedge CLK_IN) disable iff (SYS_RST_IN)
        clr_match && CLR_REQUEST_OUT && CLR_ACK_IN |=> CLR_REQUEST_OUT;
    endproperty
    a_flag_held: assert property (p_flag_held) else $error("flag cleared during match");

    property p_ack_clears;
        @(posedge CLK_IN) disable iff (SYS_RST_IN)
        SET_ACK_IN && !set_match && !set_flag_sw |=> !SET_REQUEST_OUT;
    endproperty
    a_ack_clears: assert property (p_ack_clears) else $error("ack did not clear");

    property p_set_pins;
        @(posedge CLK_IN) disable iff (SYS_RST_IN)
        s_set_event |=> ((PORT_OUT & $past(set_pins)) == $past(set_pins)) && (PORT_OE_OUT == $past(pin_enable));
    endproperty
    a_set_pins: assert property (p_set_pins) else $error("set pins not high");

    property p_clear_pins;
        @(posedge CLK_IN) disable iff (SYS_RST_IN)
        mode_two_pins && clr_hit && !set_hit |=> (PORT_OUT & $past(clr_pins)) == '0;
    endproperty
    a_clear_pins: assert property (p_clear_pins) else $error("clear pins not low");

    property p_int_only;
        @(posedge CLK_IN) disable iff (SYS_RST_IN)
        port_enables == port_compare_set_clear_pkg::PORT_INT_ONLY |=> PORT_OE_OUT == '0;
    endproperty
    a_int_only: assert property (p_int_only) else $error("pins driven in interrupt-only");

    property p_disabled;
        @(posedge CLK_IN) disable iff (SYS_RST_IN)
        port_enables == port_compare_set_clear_pkg::PORT_OFF |=> PORT_OE_OUT == '0 && $stable(PORT_OUT);
    endproperty
    a_disabled: assert property (p_disabled) else $error("port active while off");

    property p_concurrent;
        @(posedge CLK_IN) disable iff (SYS_RST_IN)
        concurrent |=> PORT_OUT[0] == $past(CH4_COMPARE_LEVEL_IN) && PORT_OE_OUT[0];
    endproperty
    a_concurrent: assert property (p_concurrent) else $error("pin does not follow");

    property p_div_one;
        @(posedge CLK_IN) disable iff (SYS_RST_IN)
        TIMER_CLOCK_TICK_IN && prescale_sel == 2'h0 |=> TIMER_TICK_OUT;
    endproperty
    a_div_one: assert property (p_div_one) else $error("divide by one lost tick");

    property p_div_two;
        @(posedge CLK_IN) disable iff (SYS_RST_IN)
        !TIMER_COUNTER_MODE_IN && prescale_sel == 2'h1 && TIMER_CLOCK_TICK_IN && prescale_count_reg == 3'h0
        |=> !TIMER_TICK_OUT;
    endproperty
    a_div_two: assert property (p_div_two) else $error("divide by two ticks twice");

    property p_reset_values;
        @(posedge CLK_IN)
        SYS_RST_IN |=> ch4_enable_reg == 8'h00 && set_mask_reg == 8'h00 && PORT_OE_OUT == '0;
    endproperty
    a_reset_values: assert property (p_reset_values) else $error("bad reset value");

    property p_set_flag_held;
        @(posedge CLK_IN) disable iff (SYS_RST_IN)
        set_match && SET_REQUEST_OUT && SET_ACK_IN |=> SET_REQUEST_OUT;
    endproperty
    a_set_flag_held: assert property (p_set_flag_held) else $error("set flag cleared during match");

    property p_clr_flag_on_match;
        @(posedge CLK_IN) disable iff (SYS_RST_IN)
        clr_match && flags_enabled |=> CLR_REQUEST_OUT;
    endproperty
    a_clr_flag_on_match: assert property (p_clr_flag_on_match) else $error("clear flag missed");

    property p_clr_ack_clears;
        @(posedge CLK_IN) disable iff (SYS_RST_IN)
        CLR_ACK_IN && !clr_match && !clr_flag_sw |=> !CLR_REQUEST_OUT;
    endproperty
    a_clr_ack_clears: assert property (p_clr_ack_clears) else $error("ack did not clear");

    property p_concurrent_oe;
        @(posedge CLK_IN) disable iff (SYS_RST_IN)
        concurrent |=> PORT_OE_OUT == $past(pin_enable);
    endproperty
    a_concurrent_oe: assert property (p_concurrent_oe) else $error("wrong pins enabled");

endmodule

`default_nettype wire

// >>> core/port_compare_set_clear_pkg.sv
// Constants for the port compare set/clear unit
package port_compare_set_clear_pkg;

    // Register addresses
    localparam logic [7:0] SET_VALUE_LOW_ADDR   = 8'hA1;
    localparam logic [7:0] SET_VALUE_HIGH_ADDR  = 8'hA2;
    localparam logic [7:0] CLR_VALUE_LOW_ADDR   = 8'hA3;
    localparam logic [7:0] CLR_VALUE_HIGH_ADDR  = 8'hA4;
    localparam logic [7:0] SET_PIN_MASK_ADDR    = 8'hA5;
    localparam logic [7:0] CLR_PIN_MASK_ADDR    = 8'hA6;
    localparam logic [7:0] CH4_ENABLE_ADDR      = 8'hC9;
    localparam logic [7:0] TIMER_CONTROL_ADDR   = 8'hE1;

    // Reset values and timer control write mask
    localparam logic [7:0] REG_RESET            = 8'h00;
    localparam logic [7:0] TIMER_CONTROL_RESET  = 8'h00;
    localparam logic [7:0] TIMER_CONTROL_MASK   = 8'hBF;

    // Channel-4 enable register fields
    localparam int EN_HIGH_BIT   = 7;
    localparam int COUNT_MSB     = 6;
    localparam int COUNT_LSB     = 4;
    localparam int EN_LOW_BIT    = 3;
    localparam int MODE_HIGH_BIT = 2;
    localparam int MODE_LOW_BIT  = 1;
    localparam int SUBMODE_BIT   = 0;

    // Timer control register fields
    localparam int PRESCALE_HIGH_BIT = 7;
    localparam int CLR_FLAG_BIT      = 5;
    localparam int SET_FLAG_BIT      = 4;

    // Channel-4 modes
    localparam logic [1:0] CH4_DISABLED      = 2'h0;
    localparam logic [1:0] CH4_CAPTURE_EDGE  = 2'h1;
    localparam logic [1:0] CH4_COMPARE       = 2'h2;
    localparam logic [1:0] CH4_CAPTURE_WRITE = 2'h3;

    // Port compare enable pairs (high, low)
    localparam logic [1:0] PORT_OFF          = 2'h0;
    localparam logic [1:0] PORT_CONCURRENT   = 2'h1;
    localparam logic [1:0] PORT_INT_ONLY     = 2'h2;
    localparam logic [1:0] PORT_MODE_TWO     = 2'h3;

    // Prescaler division counts minus one
    localparam logic [2:0] DIV_ONE_LAST   = 3'h0;
    localparam logic [2:0] DIV_TWO_LAST   = 3'h1;
    localparam logic [2:0] DIV_FOUR_LAST  = 3'h3;
    localparam logic [2:0] DIV_EIGHT_LAST = 3'h7;

endpackage

// >>> tb/port_pin_loads.sv
// Port pin loads seen by the compare outputs, with weak pull-downs
`timescale 1ns/1ps
`default_nettype none

module port_pin_loads
(
    input  wire logic [7:0] PORT_LEVEL_IN,
    input  wire logic [7:0] PORT_DRIVE_IN,
    output logic      [7:0] PIN_LEVEL_OUT
);
    // Undriven pins fall to the pull-down level
    assign PIN_LEVEL_OUT = (PORT_LEVEL_IN & PORT_DRIVE_IN);
endmodule

`default_nettype wire

// >>> tb/port_compare_set_clear_unit_tb.sv
// Self-checking bench for the port compare set/clear unit
`timescale 1ns/1ps
`default_nettype none

module port_compare_set_clear_unit_tb;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  addr = 8'h00;
    logic [7:0]  wdata = 8'h00;
    logic        wr_s = 1'b0;
    logic        rd_s = 1'b0;
    logic [7:0]  rdata;
    logic [15:0] count = 16'h0055;
    logic        tick = 1'b0;
    logic        cnt_mode = 1'b0;
    logic        ps_low = 1'b0;
    logic        tick_out;
    logic        ch4_level = 1'b0;
    logic [1:0]  ch4_mode;
    logic        submode;
    logic        set_ack = 1'b0;
    logic        clr_ack = 1'b0;
    logic        set_req;
    logic        clr_req;
    logic [7:0]  port;
    logic [7:0]  port_oe;
    logic [7:0]  pins;
    int          err_count = 0;
    int          samples_checked = 0;
    int          ticks_seen = 0;

    always #5 clk = ~clk;

    port_compare_set_clear_unit #(.PORT_WIDTH(8)) port_compare_set_clear_unit_i
    (
        .CLK_IN(clk), .SYS_RST_IN(rst), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
        .REG_WR_IN(wr_s), .REG_RD_IN(rd_s), .REG_RDATA_OUT(rdata), .TIMER_COUNT_IN(count),
        .TIMER_CLOCK_TICK_IN(tick), .TIMER_COUNTER_MODE_IN(cnt_mode), .TIMER_PRESCALE_LOW_IN(ps_low),
        .TIMER_TICK_OUT(tick_out), .CH4_COMPARE_LEVEL_IN(ch4_level), .CH4_MODE_OUT(ch4_mode),
        .CH4_SUBMODE_OUT(submode), .SET_ACK_IN(set_ack), .CLR_ACK_IN(clr_ack),
        .SET_REQUEST_OUT(set_req), .CLR_REQUEST_OUT(clr_req), .PORT_OUT(port), .PORT_OE_OUT(port_oe)
    );

    port_pin_loads port_pin_loads_i (.PORT_LEVEL_IN(port), .PORT_DRIVE_IN(port_oe), .PIN_LEVEL_OUT(pins));

    always @(posedge clk)
    begin
        if (tick_out === 1'b1)
            ticks_seen <= ticks_seen + 1;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    begin
        samples_checked = samples_checked + 1;
        if (seen !== exp)
        begin
            err_count = err_count + 1;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
    begin
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    begin
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        chk({8'h00, rdata}, {8'h00, exp});
    end
    endtask

    task automatic settle(input logic [15:0] c);
    begin
        @(posedge clk);
        count <= c;
        repeat (3) @(posedge clk);
        #1;
    end
    endtask

    task automatic pulse_ack(input logic s, input logic c);
    begin
        @(posedge clk);
        set_ack <= s;
        clr_ack <= c;
        @(posedge clk);
        set_ack <= 1'b0;
        clr_ack <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    end
    endtask

    task automatic test_registers;
        logic [7:0] regs [8];
    begin
        regs = '{8'hA1, 8'hA2, 8'hA3, 8'hA4, 8'hA5, 8'hA6, 8'hC9, 8'hE1};
        foreach (regs[i])
            rd_chk(regs[i], 8'h00);
        rd_chk(8'hB0, 8'h00);
        wr(8'hA5, 8'h5A);
        wr(8'hB0, 8'hFF);
        rd_chk(8'hA5, 8'h5A);
        wr(8'hE1, 8'h4F);
        rd_chk(8'hE1, 8'h0F);
        wr(8'hE1, 8'h00);
        for (int m = 0; m < 4; m++)
        begin
            wr(8'hC9, 8'(m << 1));
            #1;
            chk({14'h0, ch4_mode}, 16'(m));
        end
        $display("test registers done");
    end
    endtask

    task automatic test_concurrent;
    begin
        wr(8'hC9, 8'h3C);
        rd_chk(8'hC9, 8'h3D);
        chk({15'h0, submode}, 16'h0001);
        chk({14'h0, ch4_mode}, 16'h0002);
        @(posedge clk);
        ch4_level <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk({8'h00, pins}, 16'h000F);
        chk({8'h00, port_oe}, 16'h000F);
        @(posedge clk);
        ch4_level <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk({8'h00, pins}, 16'h0000);
        $display("test concurrent done");
    end
    endtask

    task automatic test_mode_two;
    begin
        wr(8'hA1, 8'h00);
        wr(8'hA2, 8'h01);
        wr(8'hA4, 8'h02);
        wr(8'hA5, 8'h3C);
        wr(8'hA6, 8'h0F);
        wr(8'hC9, 8'hFC);
        settle(16'h0100);
        chk({8'h00, port_oe}, 16'h00FF);
        chk({8'h00, pins & 8'h3C}, 16'h003C);
        chk({15'h0, set_req}, 16'h0001);
        pulse_ack(1'b1, 1'b0);
        chk({15'h0, set_req}, 16'h0001);
        settle(16'h0200);
        chk({8'h00, pins}, 16'h0030);
        chk({15'h0, clr_req}, 16'h0001);
        chk({15'h0, set_req}, 16'h0001);
        pulse_ack(1'b0, 1'b1);
        chk({15'h0, clr_req}, 16'h0001);
        settle(16'h0055);
        pulse_ack(1'b1, 1'b1);
        chk({14'h0, set_req, clr_req}, 16'h0000);
        wr(8'hA2, 8'h03);
        wr(8'hA4, 8'h03);
        settle(16'h0300);
        chk({8'h00, pins}, 16'h003C);
        settle(16'h0055);
        pulse_ack(1'b1, 1'b1);
        wr(8'hC9, 8'h84);
        settle(16'h0300);
        chk({8'h00, pins}, 16'h0000);
        chk({14'h0, set_req, clr_req}, 16'h0003);
        settle(16'h0055);
        pulse_ack(1'b1, 1'b1);
        wr(8'hC9, 8'h04);
        settle(16'h0300);
        chk({14'h0, set_req, clr_req}, 16'h0000);
        chk({8'h00, port_oe}, 16'h0000);
        $display("test mode two done");
    end
    endtask

    task automatic run_ticks(input logic hi, input logic lo, input logic cm, input int exp);
        int start_count;
    begin
        wr(8'hE1, {hi, 7'h00});
        @(posedge clk);
        ps_low <= lo;
        cnt_mode <= cm;
        start_count = ticks_seen;
        repeat (16)
        begin
            @(posedge clk);
            tick <= 1'b1;
            @(posedge clk);
            tick <= 1'b0;
        end
        repeat (3) @(posedge clk);
        chk(16'(ticks_seen - start_count), 16'(exp));
    end
    endtask

    task automatic test_prescaler;
    begin
        run_ticks(1'b0, 1'b0, 1'b0, 16);
        run_ticks(1'b0, 1'b1, 1'b0, 8);
        run_ticks(1'b1, 1'b0, 1'b0, 4);
        run_ticks(1'b1, 1'b1, 1'b0, 2);
        run_ticks(1'b0, 1'b0, 1'b1, 16);
        $display("test prescaler done");
    end
    endtask

    task automatic complete_run;
    begin
        $display("checks=%0d mismatches=%0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    end
    endtask

    initial
    begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        test_registers();
        test_concurrent();
        test_mode_two();
        test_prescaler();
        complete_run();
    end

    initial
    begin
        repeat (5000) @(posedge clk);
        err_count = err_count + 1;
        complete_run();
    end
endmodule

`default_nettype wire
